// ==== tsb_pkg.sv ====
// Shared constants and types of the time-stamp buffer status and read-out block.
package tsb_pkg;

   localparam int NUM_BUF = 3;
   localparam int CNT_W   = 6;
   localparam int IRQ_W   = 6;

   // Register indices; the Wishbone byte address is four times the index.
   localparam logic [2:0][7:0] IDX_CFG1     = {8'h2D, 8'h2A, 8'h27};
   localparam logic [2:0][7:0] IDX_STAT     = {8'h2E, 8'h2B, 8'h28};
   localparam logic [2:0][7:0] IDX_CFG2     = {8'h2F, 8'h2C, 8'h29};
   localparam logic [7:0]      IDX_IRQ_STAT = 8'h40;
   localparam logic [7:0]      IDX_IRQ_MASK = 8'h41;
   localparam logic [7:0]      IDX_MODE     = 8'h42;

   // Writable bits of each configuration register, first buffer in the low byte.
   localparam logic [2:0][7:0] CFG1_WMASK = {8'h4F, 8'h4F, 8'h7F};
   localparam logic [2:0][7:0] CFG2_WMASK = {8'h8F, 8'h8F, 8'hCF};

   // Values after reset.
   localparam logic [7:0]       CFG_RESET  = 8'h00;
   localparam logic [IRQ_W-1:0] MASK_RESET = 6'h00;
   localparam logic             MODE_RESET = 1'b0;

   // Field positions.
   localparam int FULL_BIT      = 7;
   localparam int EMPTY_BIT     = 6;
   localparam int SEL_BIT       = 7;
   localparam int MEM_BIT       = 6;
   localparam int OVW_BIT       = 6;
   localparam int MODE_FIFO_BIT = 0;
   localparam int PAGE_LSB      = 0;
   localparam int PAGE_W        = 4;

   // Capacities of the stamp stores.
   localparam int                   FIFO_DEPTH_DEF = 32;
   localparam logic [2:0][CNT_W-1:0] DIRECT_CAP    = {6'h0A, 6'h0C, 6'h0A};

   typedef enum logic [0:0] {
      WB_IDLE = 1'b0,
      WB_ACK  = 1'b1
   } tsb_wb_e;

endpackage

// ==== tsb_track_if.sv ====
// Interface between the controller and one stamp store tracker.
`timescale 1ns/10ps
`default_nettype none
interface tsb_track_if;
   logic       capture;
   logic       pop;
   logic       clear;
   logic       overwrite;
   logic [5:0] capacity;
   logic [5:0] count;
   logic [5:0] slot;
   logic [5:0] oldest;
   logic       full;
   logic       empty;
   logic       stored;
   logic       lost;

   modport tracker (
      input  capture, pop, clear, overwrite, capacity,
      output count, slot, oldest, full, empty, stored, lost
   );
   modport ctrl (
      output capture, pop, clear, overwrite, capacity,
      input  count, slot, oldest, full, empty, stored, lost
   );
endinterface
`default_nettype wire

// ==== tsb_stamp_tracker.sv ====
// Entry count and ring positions of one stamp store.
`timescale 1ns/10ps
`default_nettype none
module tsb_stamp_tracker (
   // Clock and reset
   input  wire logic          clk_i,
   input  wire logic          rst_b_i,
   // Controller side
   tsb_track_if.tracker       trk
);

   typedef struct packed {
      logic [5:0] cnt;
      logic [5:0] head;
      logic [5:0] tail;
   } tsb_trk_s;

   tsb_trk_s s_reg;
   tsb_trk_s s_next;
   logic     full;
   logic     pop_ok;
   logic     inc;

   function automatic logic [5:0] tsb_wrap(input logic [5:0] p, input logic [5:0] cap);
      tsb_wrap = (p >= cap - 6'h01) ? 6'h00 : p + 6'h01;
   endfunction

   assign full       = (s_reg.cnt == trk.capacity);
   assign pop_ok     = trk.pop & (s_reg.cnt != 6'h00);
   assign inc        = trk.capture & (~full | pop_ok);
   assign trk.full   = full;
   assign trk.empty  = (s_reg.cnt == 6'h00);
   assign trk.count  = s_reg.cnt;
   assign trk.slot   = s_reg.head;
   assign trk.oldest = s_reg.tail;
   assign trk.lost   = trk.capture & full & ~pop_ok;
   assign trk.stored = inc | (trk.lost & trk.overwrite);

   always_comb begin
      s_next = s_reg;
      if (trk.clear) begin
         s_next = '0;
      end else begin
         if (trk.stored) begin
            s_next.head = tsb_wrap(s_reg.head, trk.capacity);
         end
         // A full store in overwrite mode drops its oldest entry.
         if (pop_ok | (trk.lost & trk.overwrite)) begin
            s_next.tail = tsb_wrap(s_reg.tail, trk.capacity);
         end
         if (inc & ~pop_ok) begin
            s_next.cnt = s_reg.cnt + 6'h01;
         end else if (pop_ok & ~inc) begin
            s_next.cnt = s_reg.cnt - 6'h01;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

endmodule
`default_nettype wire

// ==== tsb_irq.sv ====
// Sticky event flags, mask and level interrupt output.
`timescale 1ns/10ps
`default_nettype none
module tsb_irq #(
   parameter int N = 6
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_b_i,
   // Events and software access
   input  wire logic [N-1:0] event_i,
   input  wire logic         rd_clr_i,
   input  wire logic [N-1:0] mask_i,
   // Results
   output logic      [N-1:0] status_o,
   output logic              irq_o
);

   typedef struct packed {
      logic [N-1:0] status;
   } tsb_irq_s;

   tsb_irq_s s_reg;
   tsb_irq_s s_next;

   always_comb begin
      s_next = s_reg;
      // An event in the clearing cycle survives the read.
      s_next.status = (rd_clr_i ? '0 : s_reg.status) | event_i;
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign status_o = s_reg.status;
   assign irq_o    = |(s_reg.status & mask_i);

endmodule
`default_nettype wire

// ==== tsb_readout_top.sv ====
// Wishbone register file, mode control and read-out selection of the stamp stores.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Full flag in status bit 7
// - Empty flag in status bit 6
// - FIFO count shows readable entries, 0 to 32
// - Direct count shows captures, limits 10/12/10
// - FIFO flags settle within 1 ms after read
// - Control bit 7 selects buffer for read-out
// - First buffer bit 6 selects memory operation
// - Page field used only when selected
// - Full store overwrites oldest or discards
module tsb_readout_top #(
   parameter int FIFO_DEPTH = tsb_pkg::FIFO_DEPTH_DEF
) (
   // Clock and reset
   input  wire logic        CLK_I,
   input  wire logic        RST_B_I,
   // Wishbone slave
   input  wire logic        CYC_I,
   input  wire logic        STB_I,
   input  wire logic        WE_I,
   input  wire logic [9:0]  ADR_I,
   input  wire logic [3:0]  SEL_I,
   input  wire logic [31:0] DAT_I,
   output logic      [31:0] DAT_O,
   output logic             ACK_O,
   // Stamp events
   input  wire logic [2:0]  CAPTURE_I,
   input  wire logic        FIFO_POP_I,
   // Read-out control
   output logic      [2:0]  READ_SELECT_O,
   output logic      [3:0]  READ_PAGE_O,
   output logic             READ_PAGE_VALID_O,
   output logic             MEMORY_MODE_O,
   output logic             FIFO_MODE_O,
   output logic      [17:0] WRITE_SLOT_O,
   output logic      [5:0]  FIFO_READ_SLOT_O,
   // Interrupt
   output logic             IRQ_O
);

   if (FIFO_DEPTH < 1 || FIFO_DEPTH > 63) begin : g_depth_check
      $error("FIFO_DEPTH must lie between 1 and 63.");
   end

   typedef struct packed {
      tsb_pkg::tsb_wb_e          wb;
      logic [31:0]               dat;
      logic [2:0][7:0]           cfg1;
      logic [2:0][7:0]           cfg2;
      logic                      fifo_mode;
      logic [tsb_pkg::IRQ_W-1:0] mask;
      logic [3:0]                page;
      logic                      page_vld;
   } tsb_top_s;

   tsb_top_s                  s_reg;
   tsb_top_s                  s_next;
   logic                      req;
   logic [7:0]                idx;
   logic [7:0]                wbyte;
   logic                      rd_clr;
   logic [2:0]                clr_a;
   logic [2:0]                cap_req;
   logic                      pop_req;
   logic [2:0][5:0]           cap_a;
   logic [2:0][5:0]           cnt_a;
   logic [2:0][5:0]           slot_a;
   logic [5:0]                oldest0;
   logic [2:0]                full_a;
   logic [2:0]                empty_a;
   logic [2:0]                stored_a;
   logic [2:0]                lost_a;
   logic [tsb_pkg::IRQ_W-1:0] irq_status;
   logic                      mem_mode;

   assign req      = CYC_I & STB_I;
   assign idx      = ADR_I[9:2];
   assign wbyte    = DAT_I[7:0];
   assign mem_mode = s_reg.cfg2[0][tsb_pkg::MEM_BIT];

   // First-store captures are refused in memory operation; pops only count in FIFO operation.
   assign cap_req = CAPTURE_I & {2'b11, ~mem_mode};
   assign pop_req = FIFO_POP_I & s_reg.fifo_mode & ~mem_mode;

   // Capacity for the active operation of each store.
   always_comb begin
      cap_a    = tsb_pkg::DIRECT_CAP;
      cap_a[0] = s_reg.fifo_mode ? 6'(FIFO_DEPTH) : tsb_pkg::DIRECT_CAP[0];
   end

   for (genvar g = 0; g < tsb_pkg::NUM_BUF; g++) begin : g_trk
      tsb_track_if trk_if ();

      assign trk_if.capture   = cap_req[g];
      assign trk_if.pop       = (g == 0) ? pop_req : 1'b0;
      assign trk_if.clear     = clr_a[g];
      assign trk_if.overwrite = s_reg.cfg1[g][tsb_pkg::OVW_BIT];
      assign trk_if.capacity  = cap_a[g];
      assign cnt_a[g]         = trk_if.count;
      assign slot_a[g]        = trk_if.slot;
      assign full_a[g]        = trk_if.full;
      assign empty_a[g]       = trk_if.empty;
      assign stored_a[g]      = trk_if.stored;
      assign lost_a[g]        = trk_if.lost;

      tsb_stamp_tracker u_trk (
         .clk_i   (CLK_I),
         .rst_b_i (RST_B_I),
         .trk     (trk_if.tracker)
      );
   end

   assign oldest0 = g_trk[0].trk_if.oldest;

   tsb_irq #(
      .N (tsb_pkg::IRQ_W)
   ) u_irq (
      .clk_i    (CLK_I),
      .rst_b_i  (RST_B_I),
      .event_i  ({lost_a, stored_a}),
      .rd_clr_i (rd_clr),
      .mask_i   (s_reg.mask),
      .status_o (irq_status),
      .irq_o    (IRQ_O)
   );

   always_comb begin
      logic [31:0] rdata;
      logic        wr;
      logic [7:0]  nv;
      rdata  = 32'h0000_0000;
      wr     = 1'b0;
      nv     = 8'h00;
      s_next = s_reg;
      rd_clr = 1'b0;
      clr_a  = 3'b000;

      // Read data, captured when the request is first seen.
      for (int b = 0; b < tsb_pkg::NUM_BUF; b++) begin
         if (idx == tsb_pkg::IDX_CFG1[b]) begin
            rdata[7:0] = s_reg.cfg1[b];
         end
         if (idx == tsb_pkg::IDX_CFG2[b]) begin
            rdata[7:0] = s_reg.cfg2[b];
         end
         if (idx == tsb_pkg::IDX_STAT[b]) begin
            rdata[tsb_pkg::FULL_BIT]  = full_a[b];
            rdata[tsb_pkg::EMPTY_BIT] = empty_a[b];
            if (b == 0) begin
               rdata[5:0] = cnt_a[b];
            end else begin
               rdata[3:0] = cnt_a[b][3:0];
            end
         end
      end
      if (idx == tsb_pkg::IDX_IRQ_STAT) begin
         rdata[tsb_pkg::IRQ_W-1:0] = irq_status;
      end
      if (idx == tsb_pkg::IDX_IRQ_MASK) begin
         rdata[tsb_pkg::IRQ_W-1:0] = s_reg.mask;
      end
      if (idx == tsb_pkg::IDX_MODE) begin
         rdata[tsb_pkg::MODE_FIFO_BIT] = s_reg.fifo_mode;
      end

      case (s_reg.wb)
         tsb_pkg::WB_IDLE: begin
            if (req) begin
               s_next.wb  = tsb_pkg::WB_ACK;
               s_next.dat = rdata;
               // Clearing at the sampling edge loses no event between sample and ack.
               if (~WE_I & (idx == tsb_pkg::IDX_IRQ_STAT)) begin
                  rd_clr = 1'b1;
               end
            end
         end
         tsb_pkg::WB_ACK: begin
            s_next.wb = tsb_pkg::WB_IDLE;
            wr        = req & WE_I & SEL_I[0];
         end
         default: begin
            s_next.wb = tsb_pkg::WB_IDLE;
         end
      endcase

      // Writes take effect on the acknowledging edge.
      if (wr) begin
         for (int b = 0; b < tsb_pkg::NUM_BUF; b++) begin
            if (idx == tsb_pkg::IDX_CFG1[b]) begin
               s_next.cfg1[b] = wbyte & tsb_pkg::CFG1_WMASK[b];
            end
            if (idx == tsb_pkg::IDX_CFG2[b]) begin
               nv             = wbyte & tsb_pkg::CFG2_WMASK[b];
               s_next.cfg2[b] = nv;
               // Entering or leaving memory operation restarts the first store.
               if (b == 0 && nv[tsb_pkg::MEM_BIT] != mem_mode) begin
                  clr_a[0] = 1'b1;
               end
            end
         end
         if (idx == tsb_pkg::IDX_IRQ_MASK) begin
            s_next.mask = wbyte[tsb_pkg::IRQ_W-1:0];
         end
         if (idx == tsb_pkg::IDX_MODE) begin
            s_next.fifo_mode = wbyte[tsb_pkg::MODE_FIFO_BIT];
            if (wbyte[tsb_pkg::MODE_FIFO_BIT] != s_reg.fifo_mode) begin
               clr_a[0] = 1'b1;
            end
         end
      end

      // The lowest selected store drives the page; unselected fields are ignored.
      s_next.page_vld = 1'b0;
      s_next.page     = 4'h0;
      for (int b = tsb_pkg::NUM_BUF - 1; b >= 0; b--) begin
         if (s_next.cfg2[b][tsb_pkg::SEL_BIT]) begin
            s_next.page_vld = 1'b1;
            s_next.page     = s_next.cfg2[b][tsb_pkg::PAGE_LSB +: tsb_pkg::PAGE_W];
         end
      end
   end

   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         s_reg.wb        <= tsb_pkg::WB_IDLE;
         s_reg.dat       <= 32'h0000_0000;
         s_reg.cfg1      <= {3{tsb_pkg::CFG_RESET}};
         s_reg.cfg2      <= {3{tsb_pkg::CFG_RESET}};
         s_reg.fifo_mode <= tsb_pkg::MODE_RESET;
         s_reg.mask      <= tsb_pkg::MASK_RESET;
         s_reg.page      <= 4'h0;
         s_reg.page_vld  <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign ACK_O             = (s_reg.wb == tsb_pkg::WB_ACK) & req;
   assign DAT_O             = s_reg.dat;
   assign READ_PAGE_O       = s_reg.page;
   assign READ_PAGE_VALID_O = s_reg.page_vld;
   assign MEMORY_MODE_O     = mem_mode;
   assign FIFO_MODE_O       = s_reg.fifo_mode;
   assign WRITE_SLOT_O      = {slot_a[2], slot_a[1], slot_a[0]};
   assign FIFO_READ_SLOT_O  = oldest0;

   for (genvar g = 0; g < tsb_pkg::NUM_BUF; g++) begin : g_sel
      assign READ_SELECT_O[g] = s_reg.cfg2[g][tsb_pkg::SEL_BIT];
   end

endmodule
`default_nettype wire

// ==== tsb_readout_chk.sv ====
// Port-level concurrent checks of the stamp buffer read-out block.
`timescale 1ns/10ps
`default_nettype none
module tsb_readout_chk #(
   parameter int FIFO_DEPTH = 32
) (
   // Clock and reset
   input  wire logic        CLK_I,
   input  wire logic        RST_B_I,
   // Wishbone
   input  wire logic        WE_I,
   input  wire logic [9:0]  ADR_I,
   input  wire logic [3:0]  SEL_I,
   input  wire logic [31:0] DAT_I,
   input  wire logic [31:0] DAT_O,
   input  wire logic        ACK_O,
   // Read-out control
   input  wire logic [2:0]  READ_SELECT_O,
   input  wire logic [3:0]  READ_PAGE_O,
   input  wire logic        READ_PAGE_VALID_O,
   input  wire logic        MEMORY_MODE_O,
   input  wire logic        FIFO_MODE_O
);
   localparam logic [5:0] DEPTH_V = 6'(FIFO_DEPTH);
   logic       rd_ack;
   logic       wr_ack;
   logic [7:0] idx;
   assign idx    = ADR_I[9:2];
   assign rd_ack = ACK_O && !WE_I;
   assign wr_ack = ACK_O && WE_I && SEL_I[0];
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);
   a_select_follows:
   assert property (wr_ack && idx == 8'h29 |=> READ_SELECT_O[0] == $past(DAT_I[7]))
      else $error("read select differs from the written bit");
   a_memory_follows:
   assert property (wr_ack && idx == 8'h29 |=> MEMORY_MODE_O == $past(DAT_I[6]))
      else $error("memory operation differs from the written bit");
   a_page_idle_zero:
   assert property ((READ_SELECT_O == 3'h0)[*2] |-> !READ_PAGE_VALID_O && READ_PAGE_O == 4'h0)
      else $error("page shown while no store is selected");
   a_full_store_one:
   assert property (rd_ack && idx == 8'h28 && !MEMORY_MODE_O |->
      DAT_O[7] == (DAT_O[5:0] == (FIFO_MODE_O ? DEPTH_V : 6'h0A)))
      else $error("first store full flag disagrees with count");
   a_full_store_two:
   assert property (rd_ack && idx == 8'h2B |-> DAT_O[7] == (DAT_O[5:0] == 6'h0C))
      else $error("second store full flag disagrees with count");
   a_empty_agrees:
   assert property (rd_ack && idx inside {8'h28, 8'h2B, 8'h2E} |-> DAT_O[6] == (DAT_O[5:0] == 6'h00))
      else $error("empty flag disagrees with count");
   a_fifo_count_max:
   assert property (rd_ack && idx == 8'h28 && FIFO_MODE_O |-> DAT_O[5:0] <= DEPTH_V)
      else $error("queue count above its depth");
   a_direct_count_max:
   assert property (rd_ack && idx == 8'h2E |-> DAT_O[5:0] <= 6'h0A)
      else $error("third store count above its limit");
endmodule
bind tsb_readout_top tsb_readout_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.CLK_I, .RST_B_I, .WE_I,
   .ADR_I, .SEL_I, .DAT_I, .DAT_O, .ACK_O, .READ_SELECT_O, .READ_PAGE_O, .READ_PAGE_VALID_O,
   .MEMORY_MODE_O, .FIFO_MODE_O);
`default_nettype wire

// ==== tsb_testbench.sv ====
// Self-checking bench of the stamp buffer read-out block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   localparam int DEPTH = 32;
   logic        CLK_I, RST_B_I, CYC_I, STB_I, WE_I, FIFO_POP_I, ACK_O, IRQ_O;
   logic        READ_PAGE_VALID_O, MEMORY_MODE_O, FIFO_MODE_O;
   logic [9:0]  ADR_I;
   logic [3:0]  SEL_I, READ_PAGE_O;
   logic [31:0] DAT_I, DAT_O;
   logic [2:0]  CAPTURE_I, READ_SELECT_O;
   logic [17:0] WRITE_SLOT_O;
   logic [5:0]  FIFO_READ_SLOT_O;
   logic [31:0] exp_q[$];
   logic [15:0] seed;
   logic [3:0]  pg;
   int          miscompares, check_count, cycles, i, k, cp;
   tsb_readout_top #(.FIFO_DEPTH(DEPTH)) dut (.CLK_I, .RST_B_I, .CYC_I, .STB_I, .WE_I, .ADR_I,
      .SEL_I, .DAT_I, .DAT_O, .ACK_O, .CAPTURE_I, .FIFO_POP_I, .READ_SELECT_O, .READ_PAGE_O,
      .READ_PAGE_VALID_O, .MEMORY_MODE_O, .FIFO_MODE_O, .WRITE_SLOT_O, .FIFO_READ_SLOT_O, .IRQ_O);
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [7:0] st(input int c, input int cap);
      return {c == cap, c == 0, 6'(c)};
   endfunction
   task automatic tally(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
      tally(got, exp);
   endtask
   task automatic cmp_port(input int sel, input logic [31:0] exp);
      logic [31:0] got;
      repeat (2) @(negedge CLK_I);
      case (sel)
         0: got = {31'h0, IRQ_O};
         1: got = {30'h0, MEMORY_MODE_O, FIFO_MODE_O};
         2: got = {24'h0, READ_PAGE_VALID_O, READ_SELECT_O, READ_PAGE_O};
         default: got = {8'h00, FIFO_READ_SLOT_O, WRITE_SLOT_O};
      endcase
      tally(got, exp);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wb(input logic [7:0] idx, input logic we, input logic [7:0] d);
      @(posedge CLK_I);
      CYC_I <= 1'h1;
      STB_I <= 1'h1;
      WE_I  <= we;
      ADR_I <= {idx, 2'h0};
      DAT_I <= {24'h0, d};
      @(posedge CLK_I);
      while (ACK_O !== 1'h1) @(posedge CLK_I);
      CYC_I <= 1'h0;
      STB_I <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      exp_q.push_back({24'h0, e});
      wb(idx, 1'h0, 8'h00);
   endtask
   task automatic ev(input logic [2:0] m, input logic p, input int n);
      repeat (n) begin
         @(posedge CLK_I);
         CAPTURE_I  <= m;
         FIFO_POP_I <= p;
      end
      @(posedge CLK_I);
      CAPTURE_I  <= 3'h0;
      FIFO_POP_I <= 1'h0;
   endtask
   initial begin
      CLK_I = 1'h0;
      forever #2 CLK_I = ~CLK_I;
   end
   always @(posedge CLK_I) begin
      cycles++;
      if (cycles == 6000) begin
         miscompares++;
         final_report();
      end
      if (ACK_O === 1'h1 && WE_I === 1'h0)
         cmp_data(DAT_O, exp_q.size() > 0 ? exp_q.pop_front() : 32'hFFFFFFFF);
   end
   initial begin
      {RST_B_I, CYC_I, STB_I, WE_I, FIFO_POP_I, CAPTURE_I} = '0;
      ADR_I = 10'h000;
      SEL_I = 4'hF;
      DAT_I = 32'h0;
      seed = 16'h4A4D;
      repeat (4) @(posedge CLK_I);
      RST_B_I <= 1'h1;
      rd(8'h10, 8'h00);
      for (i = 0; i < 3; i++) begin
         rd(8'(8'h28 + 3 * i), 8'h40);
         rd(8'(8'h29 + 3 * i), 8'h00);
         seed = lfsr(seed);
         cp = int'(tsb_pkg::DIRECT_CAP[i]);
         k = int'(seed) % cp;
         ev(3'(1 << i), 1'h0, k);
         rd(8'(8'h28 + 3 * i), st(k, cp));
         ev(3'(1 << i), 1'h0, cp - k + 1);
         rd(8'(8'h28 + 3 * i), st(cp, cp));
      end
      rd(8'h40, 8'h3F);
      rd(8'h40, 8'h00);
      wb(8'h41, 1'h1, 8'h08);
      ev(3'h4, 1'h0, 1);
      cmp_port(0, 32'h0000_0000);
      ev(3'h1, 1'h0, 1);
      cmp_port(0, 32'h0000_0001);
      rd(8'h40, 8'h28);
      cmp_port(0, 32'h0000_0000);
      wb(8'h2A, 1'h1, 8'hFF);
      rd(8'h2A, 8'h4F);
      ev(3'h2, 1'h0, 2);
      rd(8'h2B, st(12, 12));
      wb(8'h42, 1'h1, 8'h01);
      rd(8'h28, 8'h40);
      ev(3'h1, 1'h0, DEPTH + 1);
      rd(8'h28, st(DEPTH, DEPTH));
      ev(3'h0, 1'h1, 1);
      rd(8'h28, st(DEPTH - 1, DEPTH));
      ev(3'h1, 1'h1, 3);
      rd(8'h28, st(DEPTH - 1, DEPTH));
      ev(3'h0, 1'h1, DEPTH);
      rd(8'h28, 8'h40);
      cmp_port(3, {8'h00, 6'h03, 6'h00, 6'h02, 6'h03});
      wb(8'h29, 1'h1, 8'h40);
      cmp_port(1, 32'h0000_0003);
      ev(3'h1, 1'h0, 2);
      rd(8'h28, 8'h40);
      wb(8'h29, 1'h1, 8'h00);
      for (i = 0; i < 3; i++) begin
         seed = lfsr(seed);
         pg = 4'(int'(seed) % 10 + 1);
         wb(8'(8'h29 + 3 * i), 1'h1, {4'h8, pg});
         cmp_port(2, {24'h0, 1'h1, 3'(1 << i), pg});
         rd(8'(8'h29 + 3 * i), {4'h8, pg});
         wb(8'(8'h29 + 3 * i), 1'h1, {4'h0, pg});
         cmp_port(2, 32'h0000_0000);
      end
      repeat (3) @(posedge CLK_I);
      final_report();
   end
endmodule
`default_nettype wire
